// >>> hw/dmae_engine.v
`include "dmae_map.vh"
`timescale 1ns/1ps
`default_nettype none

module dmae_engine #(
  parameter AW = 8
) (
  input wire SYS_CLK,
  input wire NRST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [AW-1:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  input wire OP_VALID,
  input wire [3:0] OP_CODE,
  input wire OP_ACC_SEL,
  input wire [15:0] OP_X,
  input wire [15:0] OP_Y,
  input wire [39:0] OP_SHIFTED,
  input wire OP_BYTE,
  input wire OP_X_UNSIGNED,
  input wire OP_Y_UNSIGNED,
  input wire OP_WRITEBACK,
  output reg [31:0] MUL_RESULT,
  output reg MUL_DONE,
  output reg [15:0] WB_DATA,
  output reg WB_VALID,
  output reg TRAP_REQ,
  output wire ANY_GUARD_OVERFLOW,
  output wire ANY_SATURATED,
  output wire ROUNDING_STYLE_SELECT,
  output wire SAT_ENABLE_MEM_WRITE
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function [16:0] ext17;
    input [15:0] v;
    input uns;
    begin
      ext17 = {(uns ? 1'b0 : v[15]), v};
    end
  endfunction

  function differ;
    input [8:0] v;
    input wide;
    begin
      if (wide)
        differ = (v != 9'h000) && (v != 9'h1FF);
      else
        differ = (v[8:1] != 8'h00) && (v[8:1] != 8'hFF);
    end
  endfunction

  function [39:0] limit;
    input neg;
    input wide_rng;
    begin
      if (wide_rng)
        limit = neg ? `DMAE_MIN40 : `DMAE_MAX40;
      else
        limit = neg ? `DMAE_MIN32 : `DMAE_MAX32;
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [15:0] ctrl_reg;
  reg [2:0] trap_ctl_reg;
  reg [39:0] acc_a_reg;
  reg [39:0] acc_b_reg;
  reg guard_overflow_acc_a;
  reg guard_overflow_acc_b;
  reg saturated_acc_a;
  reg saturated_acc_b;

  wire unsigned_multiply_select = ctrl_reg[`DMAE_CTL_UNS];
  wire integer_mode = ctrl_reg[`DMAE_CTL_INT];
  wire sat_enable_acc_a = ctrl_reg[`DMAE_CTL_ASAT];
  wire sat_enable_acc_b = ctrl_reg[`DMAE_CTL_BSAT];
  wire sat_range_select = ctrl_reg[`DMAE_CTL_RANGE];

  assign ROUNDING_STYLE_SELECT = ctrl_reg[`DMAE_CTL_ROUND];
  assign SAT_ENABLE_MEM_WRITE = ctrl_reg[`DMAE_CTL_WSAT];
  assign ANY_GUARD_OVERFLOW = guard_overflow_acc_a | guard_overflow_acc_b;
  assign ANY_SATURATED = saturated_acc_a | saturated_acc_b;

  // ----------------------------------------------------------------
  // Multiplier and scaler
  // ----------------------------------------------------------------
  wire is_mul = (OP_CODE == `DMAE_OP_MUL);
  wire is_sqdiff = (OP_CODE == `DMAE_OP_SQDIFF) || (OP_CODE == `DMAE_OP_SQDACC);
  wire [15:0] diff = OP_X - OP_Y;

  reg [15:0] mx_raw;
  reg [15:0] my_raw;
  reg mx_uns;
  reg my_uns;

  always @*
  begin
    mx_raw = OP_X;
    my_raw = OP_Y;
    mx_uns = unsigned_multiply_select;
    my_uns = unsigned_multiply_select;
    if (is_mul)
    begin
      // Byte multiply is unsigned by definition
      if (OP_BYTE)
      begin
        mx_raw = {8'h00, OP_X[7:0]};
        my_raw = {8'h00, OP_Y[7:0]};
      end
      mx_uns = OP_BYTE | OP_X_UNSIGNED;
      my_uns = OP_BYTE | OP_Y_UNSIGNED;
    end
    else if (is_sqdiff)
    begin
      // Difference is always signed
      mx_raw = diff;
      my_raw = diff;
      mx_uns = 1'b0;
      my_uns = 1'b0;
    end
  end

  wire signed [16:0] mx = ext17(mx_raw, mx_uns);
  wire signed [16:0] my = ext17(my_raw, my_uns);
  wire signed [33:0] prod = mx * my;
  // Q15 x Q15 gives a doubled sign; shift left once for 1.31
  wire [32:0] scaled = integer_mode ? prod[32:0] : {prod[31:0], 1'b0};
  wire [39:0] prod40 = {{7{scaled[32]}}, scaled};

  // ----------------------------------------------------------------
  // Adder/subtracter operand steering
  // ----------------------------------------------------------------
  wire [39:0] tgt = OP_ACC_SEL ? acc_b_reg : acc_a_reg;
  wire [39:0] oth = OP_ACC_SEL ? acc_a_reg : acc_b_reg;

  reg zero_a;
  reg sub;
  reg wr;
  reg [39:0] opnd;

  always @*
  begin
    zero_a = 1'b0;
    sub = 1'b0;
    wr = OP_VALID;
    opnd = prod40;
    case (OP_CODE)
      `DMAE_OP_CLEAR:
      begin
        zero_a = 1'b1;
        opnd = 40'h0000000000;
      end
      `DMAE_OP_SQDIFF, `DMAE_OP_MULT:
        zero_a = 1'b1;
      `DMAE_OP_MULTNEG:
      begin
        zero_a = 1'b1;
        sub = 1'b1;
      end
      `DMAE_OP_SQDACC, `DMAE_OP_MULACC:
        sub = 1'b0;
      `DMAE_OP_MULSUB:
        sub = 1'b1;
      `DMAE_OP_ADDA:
        opnd = oth;
      `DMAE_OP_SUBA:
      begin
        opnd = oth;
        sub = 1'b1;
      end
      `DMAE_OP_NEG:
      begin
        zero_a = 1'b1;
        opnd = tgt;
        sub = 1'b1;
      end
      `DMAE_OP_ADDX:
        opnd = OP_SHIFTED;
      `DMAE_OP_LOAD:
      begin
        zero_a = 1'b1;
        opnd = OP_SHIFTED;
      end
      default:
        wr = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // 40-bit adder with overflow detection
  // ----------------------------------------------------------------
  wire [39:0] ain = zero_a ? 40'h0000000000 : tgt;
  wire [39:0] bin = sub ? ~opnd : opnd;
  // Borrow-in is active low, so a subtract carries in a one
  wire [40:0] sum41 = {1'b0, ain} + {1'b0, bin} + {40'h0000000000, sub};
  wire [39:0] sum = sum41[39:0];
  wire ov39 = (ain[39] == bin[39]) && (sum[39] != ain[39]);
  // On bit 39 overflow the true sign is the operands' sign
  wire true_neg = ov39 ? ain[39] : sum[39];
  wire ov31 = ov39 | differ(sum[39:31], 1'b1);

  // ----------------------------------------------------------------
  // Saturation block
  // ----------------------------------------------------------------
  wire sat_en = OP_ACC_SEL ? sat_enable_acc_b : sat_enable_acc_a;
  reg [39:0] res;
  reg new_sat;

  always @*
  begin
    res = sum;
    new_sat = ov39;
    if (sat_en && sat_range_select)
    begin
      if (ov39)
        res = limit(true_neg, 1'b1);
    end
    else if (sat_en)
    begin
      new_sat = ov31;
      if (ov31)
        res = limit(true_neg, 1'b0);
    end
  end

  // Taken from the written value; saturation to the 1.31 range can never set it
  wire new_guard = differ({res[39:32], 1'b0}, 1'b0);
  wire guard_trap_en = OP_ACC_SEL ? trap_ctl_reg[`DMAE_TRP_GB] : trap_ctl_reg[`DMAE_TRP_GA];
  wire cat_trap = trap_ctl_reg[`DMAE_TRP_CAT] & ~sat_en & new_sat;
  wire trap_next = wr & ((new_guard & guard_trap_en) | cat_trap);
  wire wr_a = wr & ~OP_ACC_SEL;
  wire wr_b = wr & OP_ACC_SEL;

  wire wb_op = (OP_CODE == `DMAE_OP_CLEAR) || (OP_CODE == `DMAE_OP_MULACC) ||
               (OP_CODE == `DMAE_OP_MULSUB) || (OP_CODE == `DMAE_OP_PREFWB);

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  wire setup = PSEL & ~PENABLE;
  wire access = PSEL & PENABLE;
  reg hit;
  reg [31:0] rd_next;

  wire [5:0] status = {ANY_SATURATED, ANY_GUARD_OVERFLOW, saturated_acc_b,
                       saturated_acc_a, guard_overflow_acc_b, guard_overflow_acc_a};

  always @*
  begin
    hit = 1'b1;
    rd_next = 32'h00000000;
    if (PADDR == `DMAE_OFS_CTRL)
      rd_next = {16'h0000, ctrl_reg};
    else if (PADDR == `DMAE_OFS_TRAP)
      rd_next = {29'h00000000, trap_ctl_reg};
    else if (PADDR == `DMAE_OFS_STAT)
      rd_next = {26'h0000000, status};
    else if (PADDR == `DMAE_OFS_AAL)
      rd_next = acc_a_reg[31:0];
    else if (PADDR == `DMAE_OFS_AAH)
      rd_next = {24'h000000, acc_a_reg[39:32]};
    else if (PADDR == `DMAE_OFS_ABL)
      rd_next = acc_b_reg[31:0];
    else if (PADDR == `DMAE_OFS_ABH)
      rd_next = {24'h000000, acc_b_reg[39:32]};
    else
      hit = 1'b0;
  end

  // Zero wait states; read data is captured in the setup cycle
  assign PREADY = 1'b1;
  assign PSLVERR = access & ~hit;

  wire wr_en = access & PWRITE & hit;
  wire wr_ctrl = wr_en && (PADDR == `DMAE_OFS_CTRL);
  wire wr_trap = wr_en && (PADDR == `DMAE_OFS_TRAP);
  wire wr_stat = wr_en && (PADDR == `DMAE_OFS_STAT);
  // Write one clears; clearing the combined bit clears both
  wire clr_sat_a = wr_stat & (PWDATA[`DMAE_ST_ASAT] | PWDATA[`DMAE_ST_ANYS]);
  wire clr_sat_b = wr_stat & (PWDATA[`DMAE_ST_BSAT] | PWDATA[`DMAE_ST_ANYS]);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      PRDATA <= 32'h00000000;
      ctrl_reg <= `DMAE_CTL_RST;
      trap_ctl_reg <= 3'h0;
    end
    else
    begin
      if (setup)
        PRDATA <= rd_next;
      if (wr_ctrl)
        ctrl_reg <= PWDATA[15:0] & `DMAE_CTL_MASK;
      if (wr_trap)
        trap_ctl_reg <= PWDATA[2:0] & `DMAE_TRP_MASK;
    end
  end

  // One decoded operation per cycle, so the core multiply and the
  // DSP path never run at once
  always @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      acc_a_reg <= 40'h0000000000;
      acc_b_reg <= 40'h0000000000;
      guard_overflow_acc_a <= 1'b0;
      guard_overflow_acc_b <= 1'b0;
      saturated_acc_a <= 1'b0;
      saturated_acc_b <= 1'b0;
      TRAP_REQ <= 1'b0;
    end
    else
    begin
      if (wr_a)
      begin
        acc_a_reg <= res;
        guard_overflow_acc_a <= new_guard;
      end
      if (wr_b)
      begin
        acc_b_reg <= res;
        guard_overflow_acc_b <= new_guard;
      end
      // Hardware set beats a software clear in the same cycle
      if (wr_a & new_sat)
        saturated_acc_a <= 1'b1;
      else if (clr_sat_a)
        saturated_acc_a <= 1'b0;
      if (wr_b & new_sat)
        saturated_acc_b <= 1'b1;
      else if (clr_sat_b)
        saturated_acc_b <= 1'b0;
      TRAP_REQ <= trap_next;
    end
  end

  always @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      MUL_RESULT <= 32'h00000000;
      MUL_DONE <= 1'b0;
      WB_DATA <= 16'h0000;
      WB_VALID <= 1'b0;
    end
    else
    begin
      MUL_DONE <= OP_VALID & is_mul;
      if (OP_VALID & is_mul)
        MUL_RESULT <= OP_BYTE ? {16'h0000, prod[15:0]} : prod[31:0];
      // Truncated high word; rounding is applied downstream
      WB_VALID <= OP_VALID & OP_WRITEBACK & wb_op;
      if (OP_VALID & OP_WRITEBACK & wb_op)
        WB_DATA <= oth[31:16];
    end
  end

endmodule // dmae_engine

`default_nettype wire

// >>> hw/dmae_map.vh
`ifndef DMAE_MAP_VH
`define DMAE_MAP_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define DMAE_OFS_CTRL 8'h00
`define DMAE_OFS_TRAP 8'h04
`define DMAE_OFS_STAT 8'h08
`define DMAE_OFS_AAL 8'h0C
`define DMAE_OFS_AAH 8'h10
`define DMAE_OFS_ABL 8'h14
`define DMAE_OFS_ABH 8'h18

// ----------------------------------------------------------------
// Core control word fields
// ----------------------------------------------------------------
`define DMAE_CTL_INT 0
`define DMAE_CTL_ROUND 1
`define DMAE_CTL_RANGE 4
`define DMAE_CTL_WSAT 5
`define DMAE_CTL_BSAT 6
`define DMAE_CTL_ASAT 7
`define DMAE_CTL_UNS 12
`define DMAE_CTL_MASK 16'h10F3
`define DMAE_CTL_RST 16'h0020

// ----------------------------------------------------------------
// Trap control word and status fields
// ----------------------------------------------------------------
`define DMAE_TRP_GA 0
`define DMAE_TRP_GB 1
`define DMAE_TRP_CAT 2
`define DMAE_TRP_MASK 3'h7
`define DMAE_ST_GA 0
`define DMAE_ST_GB 1
`define DMAE_ST_ASAT 2
`define DMAE_ST_BSAT 3
`define DMAE_ST_ANYG 4
`define DMAE_ST_ANYS 5

// ----------------------------------------------------------------
// Operation codes from the instruction decoder
// ----------------------------------------------------------------
`define DMAE_OP_NOP 4'h0
`define DMAE_OP_CLEAR 4'h1
`define DMAE_OP_SQDIFF 4'h2
`define DMAE_OP_SQDACC 4'h3
`define DMAE_OP_MULACC 4'h4
`define DMAE_OP_MULSUB 4'h5
`define DMAE_OP_MULT 4'h6
`define DMAE_OP_MULTNEG 4'h7
`define DMAE_OP_ADDA 4'h8
`define DMAE_OP_SUBA 4'h9
`define DMAE_OP_NEG 4'hA
`define DMAE_OP_ADDX 4'hB
`define DMAE_OP_LOAD 4'hC
`define DMAE_OP_MUL 4'hD
`define DMAE_OP_PREFWB 4'hE

// ----------------------------------------------------------------
// Saturation values
// ----------------------------------------------------------------
`define DMAE_MAX40 40'h7FFFFFFFFF
`define DMAE_MIN40 40'h8000000000
`define DMAE_MAX32 40'h007FFFFFFF
`define DMAE_MIN32 40'hFF80000000

`endif

// >>> verif/dmae_decoder_model.sv
`timescale 1ns/1ps
`default_nettype none

module dmae_decoder_model (
  input wire logic clk,
  output logic op_valid,
  output logic [3:0] op_code,
  output logic op_acc_sel,
  output logic [15:0] op_x,
  output logic [15:0] op_y,
  output logic [39:0] op_shifted,
  output logic [3:0] op_mode
);
  initial
  begin
    op_valid = 1'b0;
    op_code = 4'h0;
    op_acc_sel = 1'b0;
    op_x = 16'h0000;
    op_y = 16'h0000;
    op_shifted = 40'h0;
    op_mode = 4'h0;
  end

  // Mode is {write-back, byte, x unsigned, y unsigned}
  task automatic issue(input logic [3:0] c, input logic s, input logic [15:0] x,
    input logic [15:0] y, input logic [39:0] sh, input logic [3:0] m);
    @(posedge clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_acc_sel <= s;
    op_x <= x;
    op_y <= y;
    op_shifted <= sh;
    op_mode <= m;
    @(posedge clk);
    op_valid <= 1'b0;
    // Buses left stale would hide a design sampling one cycle late
    op_x <= ~x;
    op_y <= ~y;
    op_shifted <= ~sh;
  endtask
endmodule // dmae_decoder_model

`default_nettype wire

// >>> verif/dmae_engine_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "dmae_map.vh"

module dmae_engine_asserts #(
  parameter AW = 8
) (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [AW-1:0] PADDR,
  input wire logic OP_VALID,
  input wire logic [3:0] OP_CODE,
  input wire logic [15:0] OP_X,
  input wire logic [15:0] OP_Y,
  input wire logic OP_BYTE,
  input wire logic OP_X_UNSIGNED,
  input wire logic OP_Y_UNSIGNED,
  input wire logic OP_WRITEBACK,
  input wire logic [31:0] MUL_RESULT,
  input wire logic MUL_DONE,
  input wire logic WB_VALID,
  input wire logic TRAP_REQ,
  input wire logic ANY_SATURATED,
  input wire logic SAT_ENABLE_MEM_WRITE
);
  // ----------------------------------------------------------------
  // Reference products
  // ----------------------------------------------------------------
  wire [16:0] xe = {~OP_X_UNSIGNED & OP_X[15], OP_X};
  wire [16:0] ye = {~OP_Y_UNSIGNED & OP_Y[15], OP_Y};
  wire [31:0] pw = $signed(xe) * $signed(ye);
  wire [15:0] pb = OP_X[7:0] * OP_Y[7:0];
  wire stat_wr = PSEL && PENABLE && PWRITE && PADDR == `DMAE_OFS_STAT;

  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  sequence mul_word_s; OP_VALID && OP_CODE == `DMAE_OP_MUL && !OP_BYTE; endsequence
  sequence mul_byte_s; OP_VALID && OP_CODE == `DMAE_OP_MUL && OP_BYTE; endsequence
  sequence wb_ok_s;
    OP_VALID && OP_WRITEBACK &&
      OP_CODE inside {`DMAE_OP_CLEAR, `DMAE_OP_MULACC, `DMAE_OP_MULSUB, `DMAE_OP_PREFWB};
  endsequence
  sequence wb_no_s;
    OP_VALID && OP_WRITEBACK &&
      OP_CODE inside {`DMAE_OP_SQDIFF, `DMAE_OP_SQDACC, `DMAE_OP_MULT, `DMAE_OP_MULTNEG};
  endsequence

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  mul_word_a: assert property (mul_word_s |=> MUL_DONE && MUL_RESULT == $past(pw))
    else $error("word multiply result wrong");
  mul_byte_a: assert property (mul_byte_s |=> MUL_RESULT[15:0] == $past(pb))
    else $error("byte multiply result wrong");
  wb_take_a: assert property (wb_ok_s |=> WB_VALID)
    else $error("write-back missing");
  wb_refuse_a: assert property (wb_no_s |=> !WB_VALID)
    else $error("write-back given where not offered");
  idle_quiet_a: assert property (!OP_VALID |=> !MUL_DONE && !WB_VALID && !TRAP_REQ)
    else $error("event without an operation");
  trap_cause_a: assert property (TRAP_REQ |-> $past(OP_VALID))
    else $error("trap without an operation");
  sat_sticky_a: assert property (ANY_SATURATED && !stat_wr |=> ANY_SATURATED)
    else $error("saturation flag dropped");
  sat_enable_mem_write_rst_a: assert property ($rose(NRST) |-> SAT_ENABLE_MEM_WRITE)
    else $error("write saturation off after reset");
endmodule // dmae_engine_asserts

`default_nettype wire

// >>> verif/dmae_engine_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dmae_map.vh"

module dmae_engine_tb;
  typedef struct packed {
    logic [15:0] ctl;
    logic [3:0] code;
    logic sel;
    logic [15:0] x;
    logic [15:0] y;
    logic [39:0] sh;
    logic [39:0] acc;
  } dmae_row_t;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0;
  wire [31:0] prd, mres;
  wire [15:0] ox, oy, wbd;
  wire [39:0] osh;
  wire [3:0] oc, om;
  wire prdy, perr, ov, os, mdone, wbv, trap, anyg, anys, round_sel, sat_enable_mem_write;
  int n_errors = 0;
  int total_checks = 0;
  logic [31:0] rd;
  logic er;
  logic [39:0] av;
  dmae_row_t rows [13] = '{
    '{16'h0020, `DMAE_OP_MULT, 1'b0, 16'h4000, 16'h4000, 40'h0, 40'h0020000000},
    '{16'h0021, `DMAE_OP_MULTNEG, 1'b0, 16'h0003, 16'h0002, 40'h0, 40'hFFFFFFFFFA},
    '{16'h0021, `DMAE_OP_MULACC, 1'b0, 16'h0002, 16'h0005, 40'h0, 40'h0000000004},
    '{16'h0021, `DMAE_OP_MULSUB, 1'b0, 16'h0003, 16'h0003, 40'h0, 40'hFFFFFFFFFB},
    '{16'h0020, `DMAE_OP_MULT, 1'b0, 16'h8000, 16'h8000, 40'h0, 40'h0080000000},
    '{16'h1021, `DMAE_OP_MULT, 1'b0, 16'hFFFF, 16'hFFFF, 40'h0, 40'h00FFFE0001},
    '{16'h0021, `DMAE_OP_SQDIFF, 1'b0, 16'h0005, 16'h0008, 40'h0, 40'h0000000009},
    '{16'h0021, `DMAE_OP_SQDACC, 1'b0, 16'h0001, 16'h0003, 40'h0, 40'h000000000D},
    '{16'h0021, `DMAE_OP_LOAD, 1'b1, 16'h0000, 16'h0000, 40'h5, 40'h0000000005},
    '{16'h0021, `DMAE_OP_ADDA, 1'b0, 16'h0000, 16'h0000, 40'h0, 40'h0000000012},
    '{16'h0021, `DMAE_OP_SUBA, 1'b0, 16'h0000, 16'h0000, 40'h0, 40'h000000000D},
    '{16'h0021, `DMAE_OP_NEG, 1'b0, 16'h0000, 16'h0000, 40'h0, 40'hFFFFFFFFF3},
    '{16'h0021, `DMAE_OP_PREFWB, 1'b0, 16'h0000, 16'h0000, 40'h0, 40'hFFFFFFFFF3}};

  always #10 clk = ~clk;

  dmae_decoder_model dec (.clk(clk), .op_valid(ov), .op_code(oc), .op_acc_sel(os),
    .op_x(ox), .op_y(oy), .op_shifted(osh), .op_mode(om));

  dmae_engine #(.AW(8)) uut (.SYS_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
    .OP_VALID(ov), .OP_CODE(oc), .OP_ACC_SEL(os), .OP_X(ox), .OP_Y(oy), .OP_SHIFTED(osh),
    .OP_BYTE(om[2]), .OP_X_UNSIGNED(om[1]), .OP_Y_UNSIGNED(om[0]), .OP_WRITEBACK(om[3]),
    .MUL_RESULT(mres), .MUL_DONE(mdone), .WB_DATA(wbd), .WB_VALID(wbv), .TRAP_REQ(trap),
    .ANY_GUARD_OVERFLOW(anyg), .ANY_SATURATED(anys), .ROUNDING_STYLE_SELECT(round_sel),
    .SAT_ENABLE_MEM_WRITE(sat_enable_mem_write));

  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    // No wait-state count assumed; only the watchdog ends a hang
    @(posedge clk);
    while (prdy !== 1'b1)
      @(posedge clk);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    #1;
  endtask

  task automatic racc(input logic s);
    apb(1'b0, s ? `DMAE_OFS_ABH : `DMAE_OFS_AAH, 32'h0);
    av[39:32] = rd[7:0];
    apb(1'b0, s ? `DMAE_OFS_ABL : `DMAE_OFS_AAL, 32'h0);
    av[31:0] = rd;
  endtask

  task automatic go(input logic [3:0] c, input logic [39:0] sh);
    dec.issue(c, 1'b0, 16'h0000, 16'h0000, sh, 4'h0);
    #1;
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, `DMAE_OFS_CTRL, 32'h0);
    chk("ctrl", 40'h20, {8'h00, rd});
    apb(1'b0, `DMAE_OFS_STAT, 32'h0);
    chk("stat", 40'h0, {8'h00, rd});
    apb(1'b0, 8'h1C, 32'h0);
    chk("slverr", 40'h1, {39'h0, er});
    apb(1'b1, `DMAE_OFS_CTRL, 32'hFFFF);
    chk("round", 40'h1, {39'h0, round_sel});
    apb(1'b0, `DMAE_OFS_CTRL, 32'h0);
    chk("ctrl", {24'h0, `DMAE_CTL_MASK}, {8'h00, rd});
    $display("reset and map test done");
    foreach (rows[i])
    begin
      apb(1'b1, `DMAE_OFS_CTRL, {16'h0000, rows[i].ctl});
      dec.issue(rows[i].code, rows[i].sel, rows[i].x, rows[i].y, rows[i].sh, 4'h8);
      racc(rows[i].sel);
      chk("acc", rows[i].acc, av);
    end
    $display("operation table done");
    dec.issue(`DMAE_OP_MUL, 1'b0, 16'h12FF, 16'h34FF, 40'h0, 4'h4);
    #1;
    chk("mul", 40'hFE01, {24'h0, mres[15:0]});
    chk("mul_done", 40'h1, {39'h0, mdone});
    dec.issue(`DMAE_OP_MUL, 1'b0, 16'hFFFF, 16'h0002, 40'h0, 4'h2);
    #1;
    chk("mul", 40'h1FFFE, {8'h00, mres});
    dec.issue(`DMAE_OP_LOAD, 1'b1, 16'h0000, 16'h0000, 40'h0012345678, 4'h0);
    dec.issue(`DMAE_OP_PREFWB, 1'b0, 16'h0000, 16'h0000, 40'h0, 4'h8);
    #1;
    chk("wb_valid", 40'h1, {39'h0, wbv});
    chk("wb_data", 40'h1234, {24'h0, wbd});
    dec.issue(`DMAE_OP_MULT, 1'b0, 16'h0001, 16'h0001, 40'h0, 4'h8);
    #1;
    chk("wb_valid", 40'h0, {39'h0, wbv});
    apb(1'b1, `DMAE_OFS_TRAP, 32'h1);
    go(`DMAE_OP_LOAD, 40'h00FFFFFFFF);
    go(`DMAE_OP_ADDX, 40'h1);
    chk("trap", 40'h1, {39'h0, trap});
    chk("anyg", 40'h1, {39'h0, anyg});
    go(`DMAE_OP_CLEAR, 40'h0);
    chk("anyg", 40'h0, {39'h0, anyg});
    $display("multiply and guard test done");
    apb(1'b1, `DMAE_OFS_CTRL, 32'hA1);
    go(`DMAE_OP_LOAD, 40'h007FFFFFFF);
    go(`DMAE_OP_ADDX, 40'h1);
    chk("anyg", 40'h0, {39'h0, anyg});
    racc(1'b0);
    chk("acc", `DMAE_MAX32, av);
    go(`DMAE_OP_CLEAR, 40'h0);
    chk("anys", 40'h1, {39'h0, anys});
    apb(1'b1, `DMAE_OFS_CTRL, 32'hB1);
    go(`DMAE_OP_LOAD, 40'h7FFFFFFFFF);
    go(`DMAE_OP_ADDX, 40'h1);
    racc(1'b0);
    chk("acc", `DMAE_MAX40, av);
    apb(1'b1, `DMAE_OFS_STAT, 32'h20);
    chk("anys", 40'h0, {39'h0, anys});
    $display("saturation test done");
    apb(1'b1, `DMAE_OFS_CTRL, 32'h01);
    apb(1'b1, `DMAE_OFS_TRAP, 32'h4);
    go(`DMAE_OP_LOAD, 40'h7FFFFFFFFF);
    go(`DMAE_OP_ADDX, 40'h1);
    chk("trap", 40'h1, {39'h0, trap});
    chk("anys", 40'h1, {39'h0, anys});
    racc(1'b0);
    chk("acc", 40'h8000000000, av);
    $display("catastrophic test done");
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk("anys", 40'h0, {39'h0, anys});
    chk("sat_enable_mem_write", 40'h1, {39'h0, sat_enable_mem_write});
    apb(1'b0, `DMAE_OFS_CTRL, 32'h0);
    chk("ctrl", 40'h20, {8'h00, rd});
    $display("second reset test done");
    close_out();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    close_out();
  end
endmodule // dmae_engine_tb

bind dmae_engine dmae_engine_asserts #(.AW(AW)) chk_i (.SYS_CLK, .NRST, .PSEL, .PENABLE,
  .PWRITE, .PADDR, .OP_VALID, .OP_CODE, .OP_X, .OP_Y, .OP_BYTE, .OP_X_UNSIGNED,
  .OP_Y_UNSIGNED, .OP_WRITEBACK, .MUL_RESULT, .MUL_DONE, .WB_VALID, .TRAP_REQ,
  .ANY_SATURATED, .SAT_ENABLE_MEM_WRITE);

`default_nettype wire
